//--- rtf_regs.vh
// Purpose: register offsets, field positions, reset values and command codes of the framer
// Assumes: included by the framer files by bare name
// Notes: offsets are the 6-bit register addresses seen by the serial front end
`ifndef RTF_REGS_VH
`define RTF_REGS_VH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define RTF_ADDR_RX_LENGTH_LOW 6'h3b
`define RTF_ADDR_TX_SETTINGS 6'h3c
`define RTF_ADDR_TX_LENGTH_HIGH 6'h3d
`define RTF_ADDR_TX_LENGTH_LOW 6'h3e
`define RTF_ADDR_FIFO_DATA 6'h3f

// ----------------------------------------------------------------
// reset values and field positions
// ----------------------------------------------------------------
`define RTF_RST_REG 8'h00
`define RTF_TXS_CRC_SEL 3
`define RTF_TXS_FORCE_CAL 2
`define RTF_TXS_WMASK 8'h0f
`define RTF_TXL_WMASK 8'hfe

// ----------------------------------------------------------------
// direct command codes
// ----------------------------------------------------------------
`define RTF_CMD_TX_CRC 8'h90
`define RTF_CMD_TX_NOCRC 8'h91
`define RTF_CMD_QUERY 8'h98
`define RTF_CMD_SHORT_LAST 8'h9c
`define RTF_CMD_LONG_REPLY 8'h9f

// ----------------------------------------------------------------
// lengths and sizes
// ----------------------------------------------------------------
`define RTF_RXLEN_SHORT 8'h10
`define RTF_RXLEN_LONG 8'h20
`define RTF_FIFO_DEPTH 6'd48
`define RTF_FIFO_LAST 6'd47
`define RTF_CRC16_LEN 5'd16
`define RTF_CRC5_LEN 5'd5
`define RTF_CRC16_POLY 16'h1021
`define RTF_CRC16_INIT 16'hffff
`define RTF_CRC5_POLY 5'h09
`define RTF_CRC5_INIT 5'h09

`endif

//--- rtf_fifo_mem.v
// Purpose: 48-byte storage behind the cyclic framer FIFO
// Assumes: one write and one read port, read data registered
// Notes: contents are not reset; pointers in the framer define validity
`timescale 1ns/100ps
`include "rtf_regs.vh"

module rtf_fifo_mem
(
    // clock
    input wire core_clk,
    // write side
    input wire wr_en,
    input wire [5:0] wr_addr,
    input wire [7:0] wr_data,
    // read side
    input wire rd_en,
    input wire [5:0] rd_addr,
    output reg [7:0] rd_data
);

reg [7:0] mem [0:47];

always @(posedge core_clk)
begin
    if (wr_en)
    begin
        mem[wr_addr] <= wr_data;
    end
    if (rd_en)
    begin
        rd_data <= mem[rd_addr];
    end
end

endmodule

//--- rtf_framer.v
// Purpose: framing registers, cyclic FIFO and bit-level transmit/receive framing control
// Assumes: register, command and link strobes all come from logic on core_clk
// Notes: reads answer two cycles after the strobe; tx bits leave msb first
//
// Notes on behaviour
// - the low eight bits of the expected receive length live at 3bh and are preset by short commands.
// - commands 98h to 9ch load the expected receive length with sixteen bits.
// - command 9fh loads the expected receive length with thirty-two bits.
// - transmit settings bit 3 picks the appended crc, 0 for crc-16 and 1 for crc-5.
// - the query command 98h always sends the calibration period in its preamble.
// - with transmit settings bit 2 set, commands 90h and 91h also send the calibration period.
// - transmit settings bits 1 and 0 supply the session field of the query command.
// - the complete byte count is 3dh followed by bits 7 to 4 of 3eh, twelve bits in all.
// - bits 3 to 1 of 3eh count the bits of a final partial byte sent after the complete bytes.
// - the data port at 3fh reaches a 2 x 24 byte fifo that is filled and drained cyclically.
// - a reception that ends shorter than the expected length raises a short-reception error.
// - loading more bytes than the fifo buffers can take sets a sticky overflow flag.
`timescale 1ns/100ps
`include "rtf_regs.vh"

module rtf_framer
(
    // clock and reset
    input wire core_clk,
    input wire rst_n,
    // register port from the serial front end
    input wire [5:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_write,
    input wire reg_read,
    output reg [7:0] reg_rdata,
    output reg reg_rdata_valid,
    // direct commands and neighbour register bits
    input wire [7:0] cmd_code,
    input wire cmd_valid,
    input wire [3:0] rx_length_high,
    // receive link
    input wire rx_bit_valid,
    input wire rx_end,
    input wire [7:0] rx_byte,
    input wire rx_byte_valid,
    output reg rx_byte_ready,
    output reg rx_short_error,
    // transmit link
    output reg tx_bit,
    output reg tx_bit_valid,
    input wire tx_bit_ready,
    output reg tx_busy,
    output reg tx_done,
    output reg tx_calibration_preamble,
    output reg tx_crc_select,
    output reg [1:0] tx_session,
    // fifo status
    output reg [5:0] fifo_level,
    output reg fifo_overflow
);

localparam ST_IDLE = 2'd0;
localparam ST_DATA = 2'd1;
localparam ST_CRC = 2'd2;

// ----------------------------------------------------------------
// registers
// ----------------------------------------------------------------
reg [7:0] rx_length_low;
reg [7:0] tx_settings;
reg [7:0] tx_length_high;
reg [7:0] tx_length_low_and_partial;

wire wr_rxl = reg_write && (reg_addr == `RTF_ADDR_RX_LENGTH_LOW);
wire wr_fifo = reg_write && (reg_addr == `RTF_ADDR_FIFO_DATA);
wire rd_fifo = reg_read && (reg_addr == `RTF_ADDR_FIFO_DATA);
wire short_cmd = cmd_valid && (cmd_code >= `RTF_CMD_QUERY) && (cmd_code <= `RTF_CMD_SHORT_LAST);
wire long_cmd = cmd_valid && (cmd_code == `RTF_CMD_LONG_REPLY);
wire [11:0] tx_byte_count = {tx_length_high, tx_length_low_and_partial[7:4]};
wire [2:0] partial_byte_bits = tx_length_low_and_partial[3:1];

always @(posedge core_clk or negedge rst_n)
begin
    if (!rst_n)
    begin
        rx_length_low <= `RTF_RST_REG;
        tx_settings <= `RTF_RST_REG;
        tx_length_high <= `RTF_RST_REG;
        tx_length_low_and_partial <= `RTF_RST_REG;
    end
    else
    begin
        // sixteen- or thirty-two-bit command preset, wins over a host write
        if (short_cmd)
            rx_length_low <= `RTF_RXLEN_SHORT;
        else if (long_cmd)
            rx_length_low <= `RTF_RXLEN_LONG;
        else if (wr_rxl)
            rx_length_low <= reg_wdata;
        // unused high bits of the settings are kept at zero
        if (reg_write && (reg_addr == `RTF_ADDR_TX_SETTINGS))
            tx_settings <= reg_wdata & `RTF_TXS_WMASK;
        if (reg_write && (reg_addr == `RTF_ADDR_TX_LENGTH_HIGH))
            tx_length_high <= reg_wdata;
        if (reg_write && (reg_addr == `RTF_ADDR_TX_LENGTH_LOW))
            tx_length_low_and_partial <= reg_wdata & `RTF_TXL_WMASK;
    end
end

// ----------------------------------------------------------------
// cyclic fifo
// ----------------------------------------------------------------
reg [5:0] wr_ptr;
reg [5:0] rd_ptr;
reg pop_tx_q;
reg pop_host_q;
reg [1:0] buf_cnt;
reg [1:0] tx_state;
reg [12:0] fetch_left;
wire [7:0] mem_rdata;

wire rx_push = rx_byte_valid && rx_byte_ready;
wire push_req = wr_fifo || rx_push;
wire fifo_full = (fifo_level == `RTF_FIFO_DEPTH);
wire do_push = push_req && !fifo_full;
// transmit fetch, limited so the two-entry buffer never overruns
wire tx_pop = (tx_state == ST_DATA) && (fetch_left != 13'd0) && (fifo_level != 6'd0)
    && (({1'b0, buf_cnt} + {2'b00, pop_tx_q}) < 3'd2);
// transmit owns the read port while it fetches; a host read then returns zero
wire host_pop = rd_fifo && !tx_pop && (fifo_level != 6'd0);
wire do_pop = tx_pop || host_pop;

rtf_fifo_mem u_mem
(
    .core_clk(core_clk),
    .wr_en(do_push),
    .wr_addr(wr_ptr),
    .wr_data(rx_push ? rx_byte : reg_wdata),
    .rd_en(do_pop),
    .rd_addr(rd_ptr),
    .rd_data(mem_rdata)
);

always @(posedge core_clk or negedge rst_n)
begin
    if (!rst_n)
    begin
        wr_ptr <= 6'h00;
        rd_ptr <= 6'h00;
        fifo_level <= 6'h00;
        fifo_overflow <= 1'b0;
        pop_tx_q <= 1'b0;
        pop_host_q <= 1'b0;
        rx_byte_ready <= 1'b0;
    end
    else
    begin
        if (do_push)
            wr_ptr <= (wr_ptr == `RTF_FIFO_LAST) ? 6'h00 : wr_ptr + 6'h01;
        if (do_pop)
            rd_ptr <= (rd_ptr == `RTF_FIFO_LAST) ? 6'h00 : rd_ptr + 6'h01;
        fifo_level <= fifo_level + {5'h00, do_push} - {5'h00, do_pop};
        // sticky overflow, set wins over the command clear
        if ((push_req && fifo_full) || (wr_fifo && rx_push))
            fifo_overflow <= 1'b1;
        else if (cmd_valid)
            fifo_overflow <= 1'b0;
        pop_tx_q <= tx_pop;
        pop_host_q <= host_pop;
        // one slot of margin covers the registered ready
        rx_byte_ready <= (fifo_level < 6'd47);
    end
end

// ----------------------------------------------------------------
// register read answer
// ----------------------------------------------------------------
reg rd_q;
reg [5:0] rd_addr_q;
reg [7:0] next_rdata;

always @*
begin
    case (rd_addr_q)
        `RTF_ADDR_RX_LENGTH_LOW: next_rdata = rx_length_low;
        `RTF_ADDR_TX_SETTINGS: next_rdata = tx_settings;
        `RTF_ADDR_TX_LENGTH_HIGH: next_rdata = tx_length_high;
        `RTF_ADDR_TX_LENGTH_LOW: next_rdata = tx_length_low_and_partial;
        `RTF_ADDR_FIFO_DATA: next_rdata = pop_host_q ? mem_rdata : 8'h00;
        default: next_rdata = 8'h00;
    endcase
end

always @(posedge core_clk or negedge rst_n)
begin
    if (!rst_n)
    begin
        rd_q <= 1'b0;
        rd_addr_q <= 6'h00;
        reg_rdata <= 8'h00;
        reg_rdata_valid <= 1'b0;
    end
    else
    begin
        rd_q <= reg_read;
        rd_addr_q <= reg_addr;
        reg_rdata_valid <= rd_q;
        if (rd_q)
            reg_rdata <= next_rdata;
    end
end

// ----------------------------------------------------------------
// two-entry transmit buffer
// ----------------------------------------------------------------
reg [7:0] buf0;
reg [7:0] buf1;
wire buf_pop;

always @(posedge core_clk or negedge rst_n)
begin
    if (!rst_n)
    begin
        buf0 <= 8'h00;
        buf1 <= 8'h00;
        buf_cnt <= 2'd0;
    end
    else
    begin
        case ({pop_tx_q, buf_pop})
            2'b10:
            begin
                if (buf_cnt == 2'd0)
                    buf0 <= mem_rdata;
                else
                    buf1 <= mem_rdata;
                buf_cnt <= buf_cnt + 2'd1;
            end
            2'b01:
            begin
                buf0 <= buf1;
                buf_cnt <= buf_cnt - 2'd1;
            end
            2'b11:
            begin
                if (buf_cnt == 2'd1)
                    buf0 <= mem_rdata;
                else
                begin
                    buf0 <= buf1;
                    buf1 <= mem_rdata;
                end
            end
            default:
            begin
                buf_cnt <= buf_cnt;
            end
        endcase
    end
end

// ----------------------------------------------------------------
// transmit serialiser
// ----------------------------------------------------------------
reg [14:0] bits_left;
reg [7:0] shreg;
reg [3:0] sh_cnt;
reg [4:0] crc_left;
reg [15:0] crc16;
reg [4:0] crc5;
reg crc_on;

wire tx_cmd = cmd_valid && ((cmd_code == `RTF_CMD_TX_CRC) || (cmd_code == `RTF_CMD_TX_NOCRC));
wire query_cmd = cmd_valid && (cmd_code == `RTF_CMD_QUERY);
wire slot = !tx_bit_valid || tx_bit_ready;
assign buf_pop = (tx_state == ST_DATA) && slot && (bits_left != 15'd0)
    && (sh_cnt == 4'd0) && (buf_cnt != 2'd0);
wire emit_data = (tx_state == ST_DATA) && slot && (bits_left != 15'd0) && (sh_cnt != 4'd0);
wire fb16 = shreg[7] ^ crc16[15];
wire fb5 = shreg[7] ^ crc5[4];

always @(posedge core_clk or negedge rst_n)
begin
    if (!rst_n)
    begin
        tx_state <= ST_IDLE;
        bits_left <= 15'd0;
        fetch_left <= 13'd0;
        shreg <= 8'h00;
        sh_cnt <= 4'd0;
        crc_left <= 5'd0;
        crc16 <= `RTF_CRC16_INIT;
        crc5 <= `RTF_CRC5_INIT;
        crc_on <= 1'b0;
        tx_bit <= 1'b0;
        tx_bit_valid <= 1'b0;
        tx_busy <= 1'b0;
        tx_done <= 1'b0;
        tx_calibration_preamble <= 1'b0;
        tx_crc_select <= 1'b0;
        tx_session <= 2'b00;
    end
    else
    begin
        tx_done <= 1'b0;
        tx_session <= tx_settings[1:0];
        if (tx_bit_valid && tx_bit_ready)
            tx_bit_valid <= 1'b0;
        if (tx_pop)
            fetch_left <= fetch_left - 13'd1;
        case (tx_state)
            ST_IDLE:
            begin
                if (tx_cmd || query_cmd)
                begin
                    // query always, forced for plain transmits
                    tx_calibration_preamble <= query_cmd
                        || tx_settings[`RTF_TXS_FORCE_CAL];
                    // crc type latched for the frame
                    tx_crc_select <= tx_settings[`RTF_TXS_CRC_SEL];
                    crc_on <= (cmd_code != `RTF_CMD_TX_NOCRC);
                    bits_left <= {tx_byte_count, 3'b000} + {12'h000, partial_byte_bits};
                    fetch_left <= {1'b0, tx_byte_count} + {12'h000, (partial_byte_bits != 3'd0)};
                    crc16 <= `RTF_CRC16_INIT;
                    crc5 <= `RTF_CRC5_INIT;
                    sh_cnt <= 4'd0;
                    tx_busy <= 1'b1;
                    tx_state <= ST_DATA;
                end
            end
            ST_DATA:
            begin
                if (buf_pop)
                begin
                    shreg <= buf0;
                    sh_cnt <= 4'd8;
                end
                else if (emit_data)
                begin
                    tx_bit <= shreg[7];
                    tx_bit_valid <= 1'b1;
                    shreg <= {shreg[6:0], 1'b0};
                    sh_cnt <= sh_cnt - 4'd1;
                    bits_left <= bits_left - 15'd1;
                    crc16 <= {crc16[14:0], 1'b0} ^ (fb16 ? `RTF_CRC16_POLY : 16'h0000);
                    crc5 <= {crc5[3:0], 1'b0} ^ (fb5 ? `RTF_CRC5_POLY : 5'h00);
                end
                else if (slot && (bits_left == 15'd0) && !pop_tx_q)
                begin
                    // crc follows the data when enabled
                    crc_left <= tx_crc_select ? `RTF_CRC5_LEN : `RTF_CRC16_LEN;
                    tx_state <= crc_on ? ST_CRC : ST_IDLE;
                    tx_done <= !crc_on;
                    tx_busy <= crc_on;
                    tx_calibration_preamble <= tx_calibration_preamble && crc_on;
                end
            end
            ST_CRC:
            begin
                if (slot && (crc_left != 5'd0))
                begin
                    // crc-16 goes out inverted, crc-5 as held
                    tx_bit <= tx_crc_select ? crc5[4] : ~crc16[15];
                    tx_bit_valid <= 1'b1;
                    crc16 <= {crc16[14:0], 1'b0};
                    crc5 <= {crc5[3:0], 1'b0};
                    crc_left <= crc_left - 5'd1;
                end
                else if (slot)
                begin
                    tx_done <= 1'b1;
                    tx_busy <= 1'b0;
                    tx_calibration_preamble <= 1'b0;
                    tx_state <= ST_IDLE;
                end
            end
            default:
            begin
                tx_state <= ST_IDLE;
            end
        endcase
    end
end

// ----------------------------------------------------------------
// receive length check
// ----------------------------------------------------------------
reg [11:0] rx_cnt;

always @(posedge core_clk or negedge rst_n)
begin
    if (!rst_n)
    begin
        rx_cnt <= 12'h000;
        rx_short_error <= 1'b0;
    end
    else
    begin
        // compare against both length registers at frame end
        rx_short_error <= rx_end && (rx_cnt < {rx_length_high, rx_length_low});
        if (rx_end)
            rx_cnt <= 12'h000;
        else if (rx_bit_valid && (rx_cnt != 12'hfff))
            rx_cnt <= rx_cnt + 12'h001;
    end
end

endmodule

//--- rtf_framer_sva.sv
// Purpose: port assertions for the framer
// Assumes: one clock core_clk, async active-low rst_n
// Notes: bound to rtf_framer after the module
`timescale 1ns/100ps
module rtf_framer_sva
(
    // clock and reset
    input wire core_clk,
    input wire rst_n,
    // inputs
    input wire reg_read,
    input wire [7:0] cmd_code,
    input wire cmd_valid,
    input wire rx_end,
    input wire tx_bit_ready,
    // outputs
    input wire reg_rdata_valid,
    input wire rx_short_error,
    input wire tx_bit,
    input wire tx_bit_valid,
    input wire tx_busy,
    input wire tx_done,
    input wire tx_calibration_preamble,
    input wire tx_crc_select,
    input wire [5:0] fifo_level,
    input wire fifo_overflow
);
default clocking cb @(posedge core_clk);
endclocking
default disable iff (!rst_n);
AST_RD_LAT: assert property (reg_read |-> ##2 reg_rdata_valid)
    else $error("read answer not two cycles after strobe");
AST_RD_CAUSE: assert property (reg_rdata_valid |-> $past(reg_read, 2))
    else $error("read answer without a read");
AST_SHORT_ERR: assert property (rx_short_error |-> $past(rx_end))
    else $error("short error without end of reception");
AST_TX_START: assert property (cmd_valid && !tx_busy &&
    (cmd_code == 8'h90 || cmd_code == 8'h91 || cmd_code == 8'h98) |=> tx_busy)
    else $error("transmit command did not start a frame");
AST_CAL_QUERY: assert property (cmd_valid && !tx_busy && cmd_code == 8'h98
    |=> tx_calibration_preamble)
    else $error("query frame without calibration period");
AST_TX_HOLD: assert property (tx_bit_valid && !tx_bit_ready
    |=> tx_bit_valid && $stable(tx_bit))
    else $error("stalled bit changed");
AST_DONE: assert property (tx_done |-> !tx_busy && $past(tx_busy))
    else $error("done not at end of a frame");
AST_CRC_HOLD: assert property (tx_busy && $past(tx_busy) |-> $stable(tx_crc_select))
    else $error("crc type changed within frame");
AST_OVF_STICKY: assert property (fifo_overflow && !cmd_valid |=> fifo_overflow)
    else $error("overflow flag dropped without command");
AST_LEVEL: assert property (fifo_level <= 6'd48)
    else $error("fifo level above depth");
endmodule

bind rtf_framer rtf_framer_sva u_sva
(
    .core_clk(core_clk), .rst_n(rst_n), .reg_read(reg_read), .cmd_code(cmd_code),
    .cmd_valid(cmd_valid), .rx_end(rx_end), .tx_bit_ready(tx_bit_ready),
    .reg_rdata_valid(reg_rdata_valid), .rx_short_error(rx_short_error), .tx_bit(tx_bit),
    .tx_bit_valid(tx_bit_valid), .tx_busy(tx_busy), .tx_done(tx_done),
    .tx_calibration_preamble(tx_calibration_preamble), .tx_crc_select(tx_crc_select),
    .fifo_level(fifo_level), .fifo_overflow(fifo_overflow)
);

//--- rtf_tx_sink.sv
// Purpose: transmit bit sink beyond the framer
// Assumes: bits handed over on valid and ready
// Notes: stall toggles ready to test holding of bits
`timescale 1ns/100ps
module rtf_tx_sink
(
    // clock and reset
    input wire core_clk,
    input wire rst_n,
    // transmit link
    input wire tx_bit,
    input wire tx_bit_valid,
    input wire tx_busy,
    output reg tx_bit_ready,
    // control and capture
    input wire stall,
    output reg [31:0] bits,
    output reg [7:0] count
);
reg busy_q;
always @(posedge core_clk or negedge rst_n)
begin
    if (!rst_n)
    begin
        tx_bit_ready <= 1'b0;
        busy_q <= 1'b0;
        bits <= 32'h0;
        count <= 8'h00;
    end
    else
    begin
        tx_bit_ready <= !stall | !tx_bit_ready;
        busy_q <= tx_busy;
        if (tx_busy && !busy_q)
        begin
            bits <= 32'h0;
            count <= 8'h00;
        end
        else if (tx_bit_valid && tx_bit_ready)
        begin
            bits <= {bits[30:0], tx_bit};
            count <= count + 8'h01;
        end
    end
end
endmodule

//--- rfid_tx_rx_framing_regs_test.sv
// Purpose: self-checking bench for the framer
// Assumes: inputs change 1 ns after the rising edge
// Notes: register rows first, then commands, rx, tx and fifo cases
`timescale 1ns/100ps
`include "rtf_regs.vh"
module rfid_tx_rx_framing_regs_test;
reg core_clk = 1'b0;
reg rst_n = 1'b0;
reg [5:0] reg_addr = 6'h00;
reg [7:0] reg_wdata = 8'h00;
reg reg_write = 1'b0;
reg reg_read = 1'b0;
reg [7:0] cmd_code = 8'h00;
reg cmd_valid = 1'b0;
reg [3:0] rx_length_high = 4'h0;
reg rx_bit_valid = 1'b0;
reg rx_end = 1'b0;
reg [7:0] rx_byte = 8'h00;
reg rx_byte_valid = 1'b0;
reg stall = 1'b0;
wire [7:0] reg_rdata;
wire reg_rdata_valid, rx_byte_ready, rx_short_error, tx_bit, tx_bit_valid, tx_bit_ready;
wire tx_busy, tx_done, tx_calibration_preamble, tx_crc_select, fifo_overflow;
wire [1:0] tx_session;
wire [5:0] fifo_level;
wire [31:0] bits;
wire [7:0] count;
integer n_mismatch = 0;
integer tests_run = 0;
integer i, k, n_acc;
reg acc, cal, err;
reg [7:0] rd;
reg [21:0] rows [0:4];
always #5 core_clk = ~core_clk;
rtf_framer dut
(
    .core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .reg_rdata_valid(reg_rdata_valid), .cmd_code(cmd_code), .cmd_valid(cmd_valid),
    .rx_length_high(rx_length_high), .rx_bit_valid(rx_bit_valid), .rx_end(rx_end),
    .rx_byte(rx_byte), .rx_byte_valid(rx_byte_valid), .rx_byte_ready(rx_byte_ready),
    .rx_short_error(rx_short_error), .tx_bit(tx_bit), .tx_bit_valid(tx_bit_valid),
    .tx_bit_ready(tx_bit_ready), .tx_busy(tx_busy), .tx_done(tx_done),
    .tx_calibration_preamble(tx_calibration_preamble), .tx_crc_select(tx_crc_select),
    .tx_session(tx_session), .fifo_level(fifo_level), .fifo_overflow(fifo_overflow)
);
rtf_tx_sink sink
(
    .core_clk(core_clk), .rst_n(rst_n), .tx_bit(tx_bit), .tx_bit_valid(tx_bit_valid),
    .tx_busy(tx_busy), .tx_bit_ready(tx_bit_ready), .stall(stall), .bits(bits),
    .count(count)
);
task results;
begin
    $display("mismatches %0d of %0d compares", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0)
        $display("[ PASS ]");
    else
        $display("[ FAIL ]");
    $finish;
end
endtask
task chk16(input [15:0] got, input [15:0] exp);
begin
    tests_run = tests_run + 1;
    if (got !== exp)
    begin
        n_mismatch = n_mismatch + 1;
        $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
end
endtask
task chk1(input got, input exp);
begin
    chk16({15'h0, got}, {15'h0, exp});
end
endtask
task wr(input [5:0] a, input [7:0] d);
begin
    @(posedge core_clk);
    #1;
    reg_addr = a;
    reg_wdata = d;
    reg_write = 1'b1;
    @(posedge core_clk);
    #1;
    reg_write = 1'b0;
end
endtask
task rdreg(input [5:0] a);
integer w;
begin
    @(posedge core_clk);
    #1;
    reg_addr = a;
    reg_read = 1'b1;
    @(posedge core_clk);
    #1;
    reg_read = 1'b0;
    w = 0;
    while (reg_rdata_valid !== 1'b1 && w < 4)
    begin
        @(posedge core_clk);
        #1;
        w = w + 1;
    end
    rd = reg_rdata;
end
endtask
task cmd(input [7:0] c);
integer w;
begin
    @(posedge core_clk);
    #1;
    cmd_code = c;
    cmd_valid = 1'b1;
    @(posedge core_clk);
    #1;
    cmd_valid = 1'b0;
    cal = tx_calibration_preamble;
    w = 0;
    while (tx_busy === 1'b1 && w < 2000)
    begin
        @(posedge core_clk);
        #1;
        w = w + 1;
    end
end
endtask
// bits counted, then an end pulse; err is the flag one cycle on
task rxframe(input integer n);
begin
    for (k = 0; k < 2 * n; k = k + 1)
    begin
        @(posedge core_clk);
        #1;
        rx_bit_valid = !rx_bit_valid;
    end
    @(posedge core_clk);
    #1;
    rx_end = 1'b1;
    @(posedge core_clk);
    #1;
    rx_end = 1'b0;
    err = rx_short_error;
end
endtask
initial
begin
    #400000;
    n_mismatch = n_mismatch + 1;
    results;
end
initial
begin
    rows[0] = {6'h3b, 8'ha5, 8'ha5};
    rows[1] = {6'h3c, 8'hff, 8'h0f};
    rows[2] = {6'h3d, 8'h5a, 8'h5a};
    rows[3] = {6'h3e, 8'hff, 8'hfe};
    rows[4] = {6'h3a, 8'h77, 8'h00};
    repeat (12) @(posedge core_clk);
    #1;
    rst_n = 1'b1;
    for (i = 0; i < 4; i = i + 1)
    begin
        rdreg(6'h3b + i);
        chk16(rd, 16'h0);
    end
    for (i = 0; i < 5; i = i + 1)
    begin
        wr(rows[i][21:16], rows[i][15:8]);
        rdreg(rows[i][21:16]);
        chk16(rd, rows[i][7:0]);
    end
    chk16(tx_session, 16'h3);
    wr(6'h3d, 8'h00);
    wr(6'h3e, 8'h00);
    wr(6'h3c, 8'h00);
    // query first: crc-16 only frame, then the other short commands
    for (i = 0; i < 5; i = i + 1)
    begin
        cmd(8'h98 + i);
        if (i == 0)
            chk1(cal, 1'b1);
        rdreg(6'h3b);
        chk16(rd, 16'h10);
    end
    chk16(count, 16'd16);
    cmd(8'h9f);
    rdreg(6'h3b);
    chk16(rd, 16'h20);
    // host keeps the length; high bits come from the neighbour register
    rxframe(31);
    chk1(err, 1'b1);
    rxframe(32);
    chk1(err, 1'b0);
    wr(6'h3b, 8'h28);
    rxframe(40);
    chk1(err, 1'b0);
    rx_length_high = 4'h1;
    rxframe(40);
    chk1(err, 1'b1);
    // one byte plus three bits; no crc, then crc-16 and crc-5
    stall = 1'b1;
    wr(6'h3e, 8'h16);
    for (i = 0; i < 3; i = i + 1)
    begin
        wr(6'h3f, 8'ha5);
        wr(6'h3f, 8'h3c);
        wr(6'h3c, (i == 2) ? 8'h0c : 8'h04);
        cmd((i == 0) ? 8'h91 : 8'h90);
        chk1(cal, 1'b1);
        chk16(count, (i == 0) ? 16'd11 : (i == 1) ? 16'd27 : 16'd16);
        chk1(tx_crc_select, i == 2);
        if (i == 0)
            chk16(bits[15:0], 16'h0529);
        if (i == 2)
            chk16(bits[15:0], 16'ha53f);
    end
    // fill from the receive side until refused, then drain by host reads
    rx_byte_valid = 1'b1;
    n_acc = 0;
    for (k = 0; k < 60; k = k + 1)
    begin
        rx_byte = n_acc[7:0];
        acc = rx_byte_ready;
        @(posedge core_clk);
        #1;
        if (acc)
            n_acc = n_acc + 1;
    end
    rx_byte_valid = 1'b0;
    chk16(fifo_level, n_acc);
    for (i = 0; i < n_acc; i = i + 1)
    begin
        rdreg(6'h3f);
        chk16(rd, i);
    end
    rdreg(6'h3f);
    chk16({rd, 2'b00, fifo_level}, 16'h0);
    // same-cycle host and receive pushes lose the host byte
    @(posedge core_clk);
    #1;
    rx_byte_valid = 1'b1;
    reg_addr = 6'h3f;
    reg_write = 1'b1;
    @(posedge core_clk);
    #1;
    rx_byte_valid = 1'b0;
    reg_write = 1'b0;
    chk1(fifo_overflow, 1'b1);
    cmd(8'h9b);
    chk1(fifo_overflow, 1'b0);
    results;
end
endmodule
